// [pcie_capability_param_regs.v]
// Configuration-space bank of parameter-driven capability fields, reached over APB.
// Assumes an APB master on clock_in; every input is from the same clock domain.
`timescale 1ns/1ns
`include "pcie_cap_param_regs.vh"

// Behaviour
// - AER structure present only when option on.
// - ECRC check capable bit follows option.
// - ECRC generation capable bit follows option.
// - ECRC options ignored while AER is off.
// - Link port number field from parameter.
// - Slot clock bit reports common reference clock.
// - MSI multiple message capable from message count.
// - MSI-X structure present only when option on.
// - MSI-X table size field is entries minus one.
// - Table location word carries BAR indicator low.
// - Table BAR indicator legal zero through five.
// - PBA location word carries BAR indicator low.
// - PBA BAR indicator legal zero through five.
module pcie_capability_param_regs #(
  parameter AER_ON = 0,
  parameter ECRC_CHECK_ON = 0,
  parameter ECRC_GEN_ON = 0,
  parameter [7:0] PORT_NUM = 8'h01,
  parameter SLOT_CLK_ON = 0,
  parameter MSI_MSGS = 1,
  parameter MSI_64BIT = 1,
  parameter MSIX_ON = 0,
  parameter [10:0] MSIX_TABLE_SIZE = 11'h000,
  parameter [31:0] MSIX_TABLE_OFFSET = 32'h0000_0000,
  parameter [2:0] MSIX_TABLE_BIR = 3'h0,
  parameter [31:0] MSIX_MSIX_PBA_LOCATION = 32'h0000_0000,
  parameter [2:0] MSIX_PBA_BIR = 3'h0
) (
  // Clock and reset.
  input wire clock_in,
  input wire arst_n_in,
  // APB slave.
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire [3:0] pstrb_in,
  output wire [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  // Capability presence towards the application.
  output wire aer_present_out,
  output wire msix_present_out,
  // Software controls towards the application.
  output wire msi_enable_out,
  output wire [2:0] msi_mme_out,
  output wire [63:0] msi_addr_out,
  output wire [15:0] msi_data_out,
  output wire msix_enable_out,
  output wire msix_mask_out,
  output wire ecrc_check_en_out,
  output wire ecrc_gen_en_out
);

  // Fixed fields from the build options.
  wire aer_present;
  wire msix_present;
  wire ecrc_chk_cap;
  wire ecrc_gen_cap;
  wire [7:0] port_num;
  wire slot_clk;
  wire [2:0] msi_mmc;
  wire [10:0] msix_tsize;
  wire [31:0] msix_table_word;
  wire [31:0] msix_pba_word;

  // Software-writable state.
  reg msi_en_r;
  reg [2:0] msi_mme_r;
  reg [31:0] msi_addr_lo_r;
  reg [31:0] msi_addr_hi_r;
  reg [15:0] msi_data_r;
  reg msix_en_r;
  reg msix_mask_r;
  reg ecrc_chk_en_r;
  reg ecrc_gen_en_r;

  // Bus answer registers and decode.
  reg [31:0] prdata_r;
  reg [31:0] prdata_nxt;
  reg pslverr_r;
  reg hit_nxt;
  wire setup_phase;
  wire write_taken;
  wire [31:0] msi_ctrl_wr;
  wire [31:0] msix_ctrl_wr;
  wire [31:0] aer_ctrl_wr;
  wire [2:0] mme_req;

  pcie_cap_fields #(
    .AER_ON(AER_ON),
    .ECRC_CHECK_ON(ECRC_CHECK_ON),
    .ECRC_GEN_ON(ECRC_GEN_ON),
    .PORT_NUM(PORT_NUM),
    .SLOT_CLK_ON(SLOT_CLK_ON),
    .MSI_MSGS(MSI_MSGS),
    .MSIX_ON(MSIX_ON),
    .MSIX_TABLE_SIZE(MSIX_TABLE_SIZE),
    .MSIX_TABLE_OFFSET(MSIX_TABLE_OFFSET),
    .MSIX_TABLE_BIR(MSIX_TABLE_BIR),
    .MSIX_MSIX_PBA_LOCATION(MSIX_MSIX_PBA_LOCATION),
    .MSIX_PBA_BIR(MSIX_PBA_BIR)
  ) u_fields (
    .aer_present_out(aer_present),
    .msix_present_out(msix_present),
    .ecrc_chk_cap_out(ecrc_chk_cap),
    .ecrc_gen_cap_out(ecrc_gen_cap),
    .port_num_out(port_num),
    .slot_clk_out(slot_clk),
    .msi_mmc_out(msi_mmc),
    .msix_tsize_out(msix_tsize),
    .msix_table_word_out(msix_table_word),
    .msix_pba_word_out(msix_pba_word)
  );

  // Merges write data into an old word, lane by lane, as the byte strobes allow.
  function [31:0] strobe_merge;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0] strb;
    integer i;
    begin
      strobe_merge = old_word;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strobe_merge[i*8 +: 8] = new_word[i*8 +: 8];
        end
      end
    end
  endfunction

  // True when the bus address selects the given word, ignoring the byte lane bits.
  function addr_is;
    input [11:0] addr;
    input [11:0] offset;
    begin
      addr_is = (addr[`CFG_ADDR_W-1:`CFG_WORD_LSB] == offset[`CFG_ADDR_W-1:`CFG_WORD_LSB]);
    end
  endfunction

  // Every answer is ready in the first access cycle, so no wait state is ever inserted.
  assign setup_phase = psel_in && !penable_in;
  assign write_taken = psel_in && penable_in && pwrite_in;
  assign pready_out = 1'b1;
  assign prdata_out = prdata_r;
  assign pslverr_out = pslverr_r;

  // Candidate words for the writable control words, read back as they stand now.
  assign msi_ctrl_wr = strobe_merge(prdata_r, pwdata_in, pstrb_in);
  assign msix_ctrl_wr = msi_ctrl_wr;
  assign aer_ctrl_wr = msi_ctrl_wr;

  // Software may not enable more vectors than the function can raise; larger asks are cut.
  assign mme_req = (msi_ctrl_wr[`MSI_MME_LSB +: `MSI_FIELD_W] > msi_mmc) ?
                   msi_mmc : msi_ctrl_wr[`MSI_MME_LSB +: `MSI_FIELD_W];

  // Read decode: builds the word for the addressed register during the setup cycle.
  always @* begin
    prdata_nxt = `CFG_ZERO_WORD;
    hit_nxt = 1'b1;
    if (addr_is(paddr_in, `OFF_MSI_CTRL)) begin
      prdata_nxt[`CAP_ID_LSB +: `CAP_BYTE_W] = `MSI_CAP_ID;
      prdata_nxt[`CAP_NEXT_LSB +: `CAP_BYTE_W] = msix_present ? `NEXT_AFTER_MSI :
                                                                 `NEXT_AFTER_MSIX;
      prdata_nxt[`MSI_EN_BIT] = msi_en_r;
      prdata_nxt[`MSI_MMC_LSB +: `MSI_FIELD_W] = msi_mmc;
      prdata_nxt[`MSI_MME_LSB +: `MSI_FIELD_W] = msi_mme_r;
      prdata_nxt[`MSI_64B_BIT] = (MSI_64BIT != 0);
    end else if (addr_is(paddr_in, `OFF_MSI_ADDR_LO)) begin
      prdata_nxt = msi_addr_lo_r;
    end else if (addr_is(paddr_in, `OFF_MSI_ADDR_HI)) begin
      prdata_nxt = (MSI_64BIT != 0) ? msi_addr_hi_r : `CFG_ZERO_WORD;
    end else if (addr_is(paddr_in, `OFF_MSI_DATA)) begin
      prdata_nxt[`MSI_DATA_W-1:0] = msi_data_r;
    end else if (addr_is(paddr_in, `OFF_MSIX_CTRL) && msix_present) begin
      prdata_nxt[`CAP_ID_LSB +: `CAP_BYTE_W] = `MSIX_CAP_ID;
      prdata_nxt[`CAP_NEXT_LSB +: `CAP_BYTE_W] = `NEXT_AFTER_MSIX;
      prdata_nxt[`MSIX_TSIZE_LSB +: `MSIX_TSIZE_W] = msix_tsize;
      prdata_nxt[`MSIX_MASK_BIT] = msix_mask_r;
      prdata_nxt[`MSIX_EN_BIT] = msix_en_r;
    end else if (addr_is(paddr_in, `OFF_MSIX_TABLE) && msix_present) begin
      prdata_nxt = msix_table_word;
    end else if (addr_is(paddr_in, `OFF_MSIX_PBA) && msix_present) begin
      prdata_nxt = msix_pba_word;
    end else if (addr_is(paddr_in, `OFF_LINK_CAP)) begin
      prdata_nxt[`LINK_PORT_LSB +: `LINK_PORT_W] = port_num;
    end else if (addr_is(paddr_in, `OFF_LINK_CTRL)) begin
      prdata_nxt[`LINK_SLOT_CLK_BIT] = slot_clk;
    end else if (aer_present && (paddr_in >= `OFF_AER_FIRST) &&
                 (paddr_in <= `OFF_AER_LAST)) begin
      if (addr_is(paddr_in, `OFF_AER_FIRST)) begin
        prdata_nxt[`EXT_ID_LSB +: `EXT_ID_W] = `AER_EXT_ID;
        prdata_nxt[`EXT_VER_LSB +: `EXT_VER_W] = `AER_EXT_VER;
      end else if (addr_is(paddr_in, `OFF_AER_CAPCTRL)) begin
        prdata_nxt[`AER_ECRC_GEN_CAP_BIT] = ecrc_gen_cap;
        prdata_nxt[`AER_ECRC_GEN_EN_BIT] = ecrc_gen_en_r;
        prdata_nxt[`AER_ECRC_CHK_CAP_BIT] = ecrc_chk_cap;
        prdata_nxt[`AER_ECRC_CHK_EN_BIT] = ecrc_chk_en_r;
      end
    end else begin
      // Absent structures and holes, except holes inside a present AER range, answer zero with an error flag.
      hit_nxt = 1'b0;
    end
  end

  // Read data and error flag are caught at the setup cycle and held through the access.
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_r <= `CFG_ZERO_WORD;
      pslverr_r <= 1'b0;
    end else if (setup_phase) begin
      prdata_r <= prdata_nxt;
      pslverr_r <= !hit_nxt;
    end
  end

  // MSI control state; only enable and enabled-count bits take a write.
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      msi_en_r <= 1'b0;
      msi_mme_r <= 3'h0;
    end else if (write_taken && !pslverr_r && addr_is(paddr_in, `OFF_MSI_CTRL)) begin
      msi_en_r <= msi_ctrl_wr[`MSI_EN_BIT];
      msi_mme_r <= mme_req;
    end
  end

  // MSI address and data; the two low address bits stay zero for dword alignment.
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      msi_addr_lo_r <= `CFG_ZERO_WORD;
      msi_addr_hi_r <= `CFG_ZERO_WORD;
      msi_data_r <= `MSI_DATA_RST;
    end else if (write_taken && !pslverr_r) begin
      if (addr_is(paddr_in, `OFF_MSI_ADDR_LO)) begin
        msi_addr_lo_r <= strobe_merge(msi_addr_lo_r, pwdata_in, pstrb_in) &
                         `MSI_ADDR_ALIGN_MASK;
      end
      if (addr_is(paddr_in, `OFF_MSI_ADDR_HI) && (MSI_64BIT != 0)) begin
        msi_addr_hi_r <= strobe_merge(msi_addr_hi_r, pwdata_in, pstrb_in);
      end
      if (addr_is(paddr_in, `OFF_MSI_DATA)) begin
        msi_data_r <= msi_ctrl_wr[`MSI_DATA_W-1:0];
      end
    end
  end

  // MSI-X enable and function mask; table size and locations cannot be written.
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      msix_en_r <= 1'b0;
      msix_mask_r <= 1'b0;
    end else if (write_taken && !pslverr_r && msix_present &&
                 addr_is(paddr_in, `OFF_MSIX_CTRL)) begin
      msix_en_r <= msix_ctrl_wr[`MSIX_EN_BIT];
      msix_mask_r <= msix_ctrl_wr[`MSIX_MASK_BIT];
    end
  end

  // ECRC enables stick only where the matching capability is advertised.
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ecrc_chk_en_r <= 1'b0;
      ecrc_gen_en_r <= 1'b0;
    end else if (write_taken && !pslverr_r && aer_present &&
                 addr_is(paddr_in, `OFF_AER_CAPCTRL)) begin
      ecrc_chk_en_r <= aer_ctrl_wr[`AER_ECRC_CHK_EN_BIT] && ecrc_chk_cap;
      ecrc_gen_en_r <= aer_ctrl_wr[`AER_ECRC_GEN_EN_BIT] && ecrc_gen_cap;
    end
  end

  // Application-facing copies of the control state.
  assign aer_present_out = aer_present;
  assign msix_present_out = msix_present;
  assign msi_enable_out = msi_en_r;
  assign msi_mme_out = msi_mme_r;
  assign msi_addr_out = {msi_addr_hi_r, msi_addr_lo_r};
  assign msi_data_out = msi_data_r;
  assign msix_enable_out = msix_en_r;
  assign msix_mask_out = msix_mask_r;
  assign ecrc_check_en_out = ecrc_chk_en_r;
  assign ecrc_gen_en_out = ecrc_gen_en_r;

endmodule // pcie_capability_param_regs

// [pcie_cap_param_regs.vh]
// Register offsets, field positions and fixed codes of the capability parameter bank.
// Assumes a 12-bit byte address into configuration space, one aligned 32-bit word per register.
`ifndef PCIE_CAP_PARAM_REGS_VH
`define PCIE_CAP_PARAM_REGS_VH

// Address width and word layout.
`define CFG_ADDR_W 12
`define CFG_WORD_LSB 2
`define CFG_ZERO_WORD 32'h0000_0000

// Word offsets (byte addresses).
`define OFF_MSI_CTRL 12'h050
`define OFF_MSI_ADDR_LO 12'h054
`define OFF_MSI_ADDR_HI 12'h058
`define OFF_MSI_DATA 12'h05c
`define OFF_MSIX_CTRL 12'h068
`define OFF_MSIX_TABLE 12'h06c
`define OFF_MSIX_PBA 12'h070
`define OFF_LINK_CAP 12'h090
`define OFF_LINK_CTRL 12'h094
`define OFF_AER_FIRST 12'h800
`define OFF_AER_CAPCTRL 12'h818
`define OFF_AER_LAST 12'h834

// Capability identifiers and next-capability pointers.
`define MSI_CAP_ID 8'h05
`define MSIX_CAP_ID 8'h11
`define AER_EXT_ID 16'h0001
`define AER_EXT_VER 4'h2
`define NEXT_AFTER_MSI 8'h68
`define NEXT_AFTER_MSIX 8'h80

// Message control fields inside the word at 0x050.
`define MSI_EN_BIT 16
`define MSI_MMC_LSB 17
`define MSI_MME_LSB 20
`define MSI_64B_BIT 23
`define MSI_FIELD_W 3
`define MSI_ADDR_ALIGN_MASK 32'hffff_fffc

// MSI-X control fields inside the word at 0x068, and BAR indicator codes of the location words.
`define MSIX_TSIZE_LSB 16
`define MSIX_TSIZE_W 11
`define MSIX_MASK_BIT 30
`define MSIX_EN_BIT 31
`define BIR_W 3
`define BIR_MAX 3'h5
`define BIR_FALLBACK 3'h0

// Link capability and link status fields.
`define LINK_PORT_LSB 24
`define LINK_PORT_W 8
`define LINK_SLOT_CLK_BIT 28

// AER capabilities and control bits.
`define AER_ECRC_GEN_CAP_BIT 5
`define AER_ECRC_GEN_EN_BIT 6
`define AER_ECRC_CHK_CAP_BIT 7
`define AER_ECRC_CHK_EN_BIT 8

// Common capability header fields and MSI data width.
`define CAP_ID_LSB 0
`define CAP_NEXT_LSB 8
`define CAP_BYTE_W 8
`define EXT_ID_LSB 0
`define EXT_ID_W 16
`define EXT_VER_LSB 16
`define EXT_VER_W 4
`define MSI_DATA_W 16
`define MSI_DATA_RST 16'h0000

`endif

// [pcie_cap_fields.v]
// Build-time derivation of the read-only capability fields from the option parameters.
// Assumes constant parameters; every output is a constant once the design is elaborated.
`timescale 1ns/1ns
`include "pcie_cap_param_regs.vh"

module pcie_cap_fields #(
  parameter AER_ON = 0,
  parameter ECRC_CHECK_ON = 0,
  parameter ECRC_GEN_ON = 0,
  parameter [7:0] PORT_NUM = 8'h01,
  parameter SLOT_CLK_ON = 0,
  parameter MSI_MSGS = 1,
  parameter MSIX_ON = 0,
  parameter [10:0] MSIX_TABLE_SIZE = 11'h000,
  parameter [31:0] MSIX_TABLE_OFFSET = 32'h0000_0000,
  parameter [2:0] MSIX_TABLE_BIR = 3'h0,
  parameter [31:0] MSIX_MSIX_PBA_LOCATION = 32'h0000_0000,
  parameter [2:0] MSIX_PBA_BIR = 3'h0
) (
  // Presence of optional structures.
  output wire aer_present_out,
  output wire msix_present_out,
  // Error reporting capability bits.
  output wire ecrc_chk_cap_out,
  output wire ecrc_gen_cap_out,
  // Link fields.
  output wire [7:0] port_num_out,
  output wire slot_clk_out,
  // Message fields.
  output wire [2:0] msi_mmc_out,
  output wire [10:0] msix_tsize_out,
  output wire [31:0] msix_table_word_out,
  output wire [31:0] msix_pba_word_out
);

  // Encodes a message count as its power of two; an illegal count falls back to one message.
  function [2:0] msg_count_code;
    input integer count;
    begin
      case (count)
        1: msg_count_code = 3'h0;
        2: msg_count_code = 3'h1;
        4: msg_count_code = 3'h2;
        8: msg_count_code = 3'h3;
        16: msg_count_code = 3'h4;
        default: msg_count_code = 3'h0;
      endcase
    end
  endfunction

  // Only six BARs exist, so an indicator above five is forced back to the first BAR.
  function [2:0] legal_bir;
    input [2:0] bir;
    begin
      legal_bir = (bir > `BIR_MAX) ? `BIR_FALLBACK : bir;
    end
  endfunction

  // Low three bits carry the indicator, leaving the offset qword aligned.
  function [31:0] location_word;
    input [31:0] offset;
    input [2:0] bir;
    begin
      location_word = {offset[31:`BIR_W], legal_bir(bir)};
    end
  endfunction

  // Optional structures.
  assign aer_present_out = (AER_ON != 0);
  assign msix_present_out = (MSIX_ON != 0);

  // ECRC capability is only advertised when the AER structure exists.
  assign ecrc_chk_cap_out = (ECRC_CHECK_ON != 0) && (AER_ON != 0);
  assign ecrc_gen_cap_out = (ECRC_GEN_ON != 0) && (AER_ON != 0);

  // Link fields.
  assign port_num_out = PORT_NUM;
  assign slot_clk_out = (SLOT_CLK_ON != 0);

  // Message fields.
  assign msi_mmc_out = msg_count_code(MSI_MSGS);
  assign msix_tsize_out = MSIX_TABLE_SIZE;
  assign msix_table_word_out = location_word(MSIX_TABLE_OFFSET, MSIX_TABLE_BIR);
  assign msix_pba_word_out = location_word(MSIX_MSIX_PBA_LOCATION, MSIX_PBA_BIR);

endmodule // pcie_cap_fields

// [pcie_cap_param_checker_properties.sv]
// Checker for the capability bank: read-only fields as seen on its APB port.
// Assumes one clock domain and the zero-wait APB answer of the bank.
`timescale 1ns/1ns
module pcie_cap_param_checker #(
  parameter AER_ON = 0,
  parameter ECRC_CHECK_ON = 0,
  parameter ECRC_GEN_ON = 0,
  parameter [7:0] PORT_NUM = 8'h01,
  parameter SLOT_CLK_ON = 0,
  parameter MSI_MSGS = 1,
  parameter MSIX_ON = 0,
  parameter [10:0] MSIX_TABLE_SIZE = 11'h000,
  parameter [31:0] MSIX_TABLE_OFFSET = 32'h0000_0000,
  parameter [2:0] MSIX_TABLE_BIR = 3'h0,
  parameter [31:0] MSIX_MSIX_PBA_LOCATION = 32'h0000_0000,
  parameter [2:0] MSIX_PBA_BIR = 3'h0
) (
  // Clock and reset.
  input wire clock_in,
  input wire arst_n_in,
  // APB slave side.
  input wire psel_in,
  input wire penable_in,
  input wire [11:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  // Presence flags.
  input wire aer_present_out,
  input wire msix_present_out
);
  // Expected fields; an illegal indicator reads as zero.
  localparam AER = (AER_ON != 0);
  localparam MSIX = (MSIX_ON != 0);
  localparam [2:0] MMC = (MSI_MSGS == 2) ? 3'h1 : (MSI_MSGS == 4) ? 3'h2 :
    (MSI_MSGS == 8) ? 3'h3 : (MSI_MSGS == 16) ? 3'h4 : 3'h0;
  localparam [2:0] TBIR = (MSIX_TABLE_BIR > 3'h5) ? 3'h0 : MSIX_TABLE_BIR;
  localparam [2:0] PBIR = (MSIX_PBA_BIR > 3'h5) ? 3'h0 : MSIX_PBA_BIR;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);
  // Setup cycle aimed at one word; the answer is loaded at that edge.
  sequence s_setup(logic [11:0] a);
    psel_in && !penable_in && paddr_in[11:2] == a[11:2];
  endsequence
  // Any cycle that is not a setup cycle.
  sequence s_no_setup;
    !(psel_in && !penable_in);
  endsequence
  a_ready_high: assert property (pready_out)
    else $error("pready low");
  a_aer_flag: assert property (aer_present_out == AER)
    else $error("aer presence wrong");
  a_msix_flag: assert property (msix_present_out == MSIX)
    else $error("msix presence wrong");
  a_read_stands: assert property (s_no_setup |=> $stable(prdata_out))
    else $error("read data moved");
  a_port_num: assert property (s_setup(12'h090) |=> prdata_out[31:24] == PORT_NUM)
    else $error("port number wrong");
  a_slot_clk: assert property (s_setup(12'h094) |=> prdata_out[28] == (SLOT_CLK_ON != 0))
    else $error("slot clock bit wrong");
  a_msi_mmc: assert property (s_setup(12'h050) |=> prdata_out[19:17] == MMC)
    else $error("message capable field wrong");
  a_table_size: assert property (s_setup(12'h068) |=>
    (MSIX ? prdata_out[26:16] == MSIX_TABLE_SIZE : pslverr_out))
    else $error("table size wrong");
  a_table_word: assert property (s_setup(12'h06c) |=>
    prdata_out == (MSIX ? {MSIX_TABLE_OFFSET[31:3], TBIR} : 32'h0))
    else $error("table location wrong");
  a_pba_word: assert property (s_setup(12'h070) |=>
    prdata_out == (MSIX ? {MSIX_MSIX_PBA_LOCATION[31:3], PBIR} : 32'h0))
    else $error("pba location wrong");
  a_aer_head: assert property (s_setup(12'h800) |=>
    (AER ? prdata_out[15:0] == 16'h0001 && !pslverr_out : pslverr_out))
    else $error("error reporting header wrong");
  a_ecrc_caps: assert property (s_setup(12'h818) |=>
    prdata_out[7] == (AER && ECRC_CHECK_ON != 0) && prdata_out[5] == (AER && ECRC_GEN_ON != 0))
    else $error("ecrc capable bits wrong");
endmodule // pcie_cap_param_checker

// Attach to every instance of the bank.
bind pcie_capability_param_regs pcie_cap_param_checker #(.AER_ON(AER_ON),
  .ECRC_CHECK_ON(ECRC_CHECK_ON), .ECRC_GEN_ON(ECRC_GEN_ON), .PORT_NUM(PORT_NUM),
  .SLOT_CLK_ON(SLOT_CLK_ON), .MSI_MSGS(MSI_MSGS), .MSIX_ON(MSIX_ON),
  .MSIX_TABLE_SIZE(MSIX_TABLE_SIZE), .MSIX_TABLE_OFFSET(MSIX_TABLE_OFFSET),
  .MSIX_TABLE_BIR(MSIX_TABLE_BIR), .MSIX_MSIX_PBA_LOCATION(MSIX_MSIX_PBA_LOCATION),
  .MSIX_PBA_BIR(MSIX_PBA_BIR)) pcie_cap_param_checker_inst (.clock_in(clock_in),
  .arst_n_in(arst_n_in), .psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .aer_present_out(aer_present_out), .msix_present_out(msix_present_out));

// [pcie_capability_param_regs_test.sv]
// Bench of the capability bank: one bank with every option but ECRC generation, and one at defaults plus both ECRC options.
// Assumes both banks share one APB master and answer with pready high.
`timescale 1ns/1ns
module pcie_capability_param_regs_test;
  localparam [7:0] PORT = 8'h5a;
  localparam [31:0] TOFF = 32'h0001_234f;
  localparam [31:0] POFF = 32'h00ab_cdef;
  // Build options of the optioned bank (all but ECRC generation); the pba indicator is illegal on purpose.
  localparam ON = 1;
  localparam MSGS = 8;
  localparam [10:0] TSIZE = 11'h7ff;
  localparam [2:0] TBIR = 3'h5;
  localparam [2:0] PBIR = 3'h6;
  localparam [119:0] ADDRS = {12'h050, 12'h068, 12'h06c, 12'h070, 12'h090,
    12'h094, 12'h800, 12'h818, 12'h000, 12'hffc};
  reg clock_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg psel_in = 1'b0;
  reg penable_in = 1'b0;
  reg pwrite_in = 1'b0;
  reg [11:0] paddr_in = 12'h000;
  reg [31:0] pwdata_in = 32'h0;
  reg [3:0] pstrb_in = 4'h0;
  wire [31:0] prdata_a, prdata_b;
  wire pready_a, pready_b, pslverr_a, pslverr_b, aer_a, aer_b, msix_a, msix_b, chk_en, gen_en;
  wire chk_en_b, gen_en_b, msi_en, mx_en, mx_mask, mx_en_b;
  wire [2:0] mme;
  wire [63:0] maddr;
  wire [15:0] mdata;
  reg [31:0] rd_a, rd_b;
  reg err_a, err_b;
  reg [15:0] lfsr = 16'h003b;
  integer n_mismatch = 0;
  integer tests_run = 0;
  integer i;

  // Clock of 40 ns period.
  always #20 clock_in = ~clock_in;

  // Optioned bank; the pba indicator is illegal on purpose.
  pcie_capability_param_regs #(.AER_ON(ON), .ECRC_CHECK_ON(ON), .PORT_NUM(PORT), .SLOT_CLK_ON(ON),
    .MSI_MSGS(MSGS), .MSIX_ON(ON), .MSIX_TABLE_SIZE(TSIZE), .MSIX_TABLE_OFFSET(TOFF),
    .MSIX_TABLE_BIR(TBIR), .MSIX_MSIX_PBA_LOCATION(POFF), .MSIX_PBA_BIR(PBIR))
    pcie_capability_param_regs_inst (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_a), .pready_out(pready_a),
    .pslverr_out(pslverr_a), .aer_present_out(aer_a), .msix_present_out(msix_a),
    .msi_enable_out(msi_en), .msi_mme_out(mme), .msi_addr_out(maddr), .msi_data_out(mdata),
    .msix_enable_out(mx_en), .msix_mask_out(mx_mask), .ecrc_check_en_out(chk_en),
    .ecrc_gen_en_out(gen_en));
  // Default bank, but with both ecrc options asked for while error reporting is off.
  pcie_capability_param_regs #(.ECRC_CHECK_ON(ON), .ECRC_GEN_ON(ON))
    pcie_capability_param_regs_inst_dflt (.clock_in(clock_in), .arst_n_in(arst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_b), .pready_out(pready_b),
    .pslverr_out(pslverr_b), .aer_present_out(aer_b), .msix_present_out(msix_b),
    .msi_enable_out(), .msi_mme_out(), .msi_addr_out(), .msi_data_out(),
    .msix_enable_out(mx_en_b), .msix_mask_out(), .ecrc_check_en_out(chk_en_b),
    .ecrc_gen_en_out(gen_en_b));

  // Pseudo-random source.
  function [15:0] nxt(input [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Location word: offset with the low three bits replaced by a legal indicator.
  function [31:0] exp_loc(input [31:0] off, input [2:0] bir);
    exp_loc = {off[31:3], (bir > 3'h5) ? 3'h0 : bir};
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // Masked compare.
  task chk(input [31:0] got, input [31:0] exp, input [31:0] mask);
    begin
      tests_run = tests_run + 1;
      if ((got & mask) !== (exp & mask)) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: got %h expected %h mask %h", $time, got, exp, mask);
      end
    end
  endtask

  // One APB transfer to both banks; the request holds until pready is seen.
  task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
    integer k;
    begin
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      pstrb_in <= s;
      @(posedge clock_in);
      penable_in <= 1'b1;
      k = 0;
      do begin
        @(posedge clock_in);
        k = k + 1;
      end while (!(pready_a === 1'b1 && pready_b === 1'b1) && k < 16);
      chk(k, 1, 32'hffff_ffff);
      rd_a = prdata_a;
      err_a = pslverr_a;
      rd_b = prdata_b;
      err_b = pslverr_b;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clock_in);
    end
  endtask

  // Optional write, then a read whose fields are compared on both banks, the two location words on the optioned bank only.
  task probe(input w, input [11:0] a, input [31:0] d, input [3:0] s);
    reg bad;
    begin
      bad = (a == 12'h000 || a == 12'hffc);
      if (w)
        apb(1'b1, a, d, s);
      if (w)
        chk({31'h0, err_a}, {31'h0, bad}, 32'h1);
      apb(1'b0, a, 32'h0, 4'h0);
      chk({31'h0, err_a}, {31'h0, bad}, 32'h1);
      case (a)
        12'h050: begin
          chk(rd_a, 32'h0006_0005, 32'h000e_00ff);
          chk(rd_b, 32'h0000_0005, 32'h000e_00ff);
        end
        12'h068: begin
          chk(rd_a, {5'h00, TSIZE, 16'h0011}, 32'h07ff_00ff);
          chk({31'h0, err_b}, 32'h1, 32'h1);
        end
        12'h06c: chk(rd_a, exp_loc(TOFF, TBIR), 32'hffff_ffff);
        12'h070: chk(rd_a, exp_loc(POFF, PBIR), 32'hffff_ffff);
        12'h090: begin
          chk(rd_a, {PORT, 24'h0}, 32'hff00_0000);
          chk(rd_b, 32'h0100_0000, 32'hff00_0000);
        end
        12'h094: begin
          chk(rd_a, 32'h1000_0000, 32'h1000_0000);
          chk(rd_b, 32'h0, 32'h1000_0000);
        end
        12'h800: begin
          chk(rd_a, 32'h0002_0001, 32'h000f_ffff);
          chk({err_b, rd_b[30:0]}, 32'h8000_0000, 32'hffff_ffff);
        end
        12'h818: begin
          chk(rd_a, 32'h80, 32'ha0);
          chk({err_b, rd_b[30:0]}, 32'h8000_0000, 32'hffff_ffff);
        end
        default: chk({31'h0, err_b}, 32'h1, 32'h1);
      endcase
    end
  endtask

  // Watchdog well beyond the expected run of about 540 cycles.
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    stop_test;
  end

  // Reset, plain reads, random writes over the ten probed words, enable bits.
  initial begin
    repeat (8) @(posedge clock_in);
    arst_n_in <= 1'b1;
    @(posedge clock_in);
    chk({aer_a, msix_a, aer_b, msix_b}, 32'hc, 32'hf);
    for (i = 0; i < 10; i = i + 1)
      probe(1'b0, ADDRS[12*i +: 12], 32'h0, 4'h0);
    for (i = 0; i < 80; i = i + 1) begin
      lfsr = nxt(lfsr);
      probe(1'b1, ADDRS[12*(lfsr%10) +: 12], {lfsr, nxt(lfsr)}, lfsr[15:12]);
    end
    apb(1'b1, 12'h818, 32'h0000_0140, 4'hf);
    chk({chk_en, gen_en}, 32'h2, 32'h3);
    chk({chk_en_b, gen_en_b}, 32'h0, 32'h3);
    apb(1'b1, 12'h818, 32'h0, 4'hf);
    chk({chk_en, gen_en}, 32'h0, 32'h3);
    // Control words: an enabled count above the capable count is cut back to it.
    apb(1'b1, 12'h050, 32'h0071_0000, 4'hc);
    chk({28'h0, msi_en, mme}, 32'hb, 32'hf);
    apb(1'b1, 12'h054, 32'hffff_ffff, 4'hf);
    chk(maddr[31:0], 32'hffff_fffc, 32'hffff_ffff);
    apb(1'b1, 12'h058, 32'h1234_5678, 4'hf);
    chk(maddr[63:32], 32'h1234_5678, 32'hffff_ffff);
    apb(1'b1, 12'h05c, 32'hffff_a5c3, 4'h3);
    chk({16'h0, mdata}, 32'h0000_a5c3, 32'hffff_ffff);
    // An absent MSI-X structure must ignore the same enable write.
    apb(1'b1, 12'h068, 32'hc000_0000, 4'h8);
    chk({29'h0, mx_en, mx_mask, mx_en_b}, 32'h6, 32'h7);
    stop_test;
  end
endmodule // pcie_capability_param_regs_test
